/* jk_element.sv */
// one jk storage element with falling-edge clock and direct preset/clear
`default_nettype none
module jk_element (
    // system
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // board pins
    input  wire jk_pair_pkg::pins_s pins,
    // outputs
    output var  jk_pair_pkg::outs_s outs
);

    jk_pair_pkg::pins_s sync1_q, sync1_d;
    jk_pair_pkg::pins_s sync2_q, sync2_d;
    jk_pair_pkg::pins_s prev_q,  prev_d;
    logic               state_q, state_d;
    jk_pair_pkg::outs_s outs_q,  outs_d;
    logic               fall_edge;
    logic               pre_on;
    logic               clr_on;

    // two-stage synchroniser plus one history stage; sync2 and the history stage prev feed logic
    always_comb begin
        sync1_d = pins;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync1_q <= jk_pair_pkg::PINS_IDLE;
            sync2_q <= jk_pair_pkg::PINS_IDLE;
            prev_q  <= jk_pair_pkg::PINS_IDLE;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // high-to-low of the synchronised clock pin; rising edges are ignored
    assign fall_edge = prev_q.falling_edge_clock & ~sync2_q.falling_edge_clock;
    assign pre_on    = ~sync2_q.direct_preset_n;
    assign clr_on    = ~sync2_q.direct_clear_n;

    // next state; requests taken from the sample before the edge, so a
    // request moving together with the clock pin cannot race it
    always_comb begin
        state_d = state_q;
        if (pre_on) begin
            state_d = 1'b1;
        end else if (clr_on) begin
            state_d = 1'b0;
        end else if (fall_edge) begin
            unique case ({prev_q.set_req, prev_q.reset_req})
                2'b00: state_d = state_q;
                2'b01: state_d = 1'b0;
                2'b10: state_d = 1'b1;
                2'b11: state_d = ~state_q;
            endcase
        end
        // both direct inputs low drive both outputs high
        outs_d.q   = state_d | pre_on;
        outs_d.q_n = ~state_d | clr_on;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= jk_pair_pkg::RST_STATE;
            outs_q  <= '{q: jk_pair_pkg::RST_STATE, q_n: ~jk_pair_pkg::RST_STATE};
        end else begin
            state_q <= state_d;
            outs_q  <= outs_d;
        end
    end

    assign outs = outs_q;

    // checks
    logic quiet;
    assign quiet = ~pre_on & ~clr_on;

    toggle_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fall_edge && quiet && prev_q.set_req && prev_q.reset_req
        |=> outs.q == !$past(outs.q))
        else $error("toggle did not invert state");

    hold_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fall_edge && quiet && !prev_q.set_req && !prev_q.reset_req
        ##1 !outs.q_n == outs.q |-> $stable(outs.q))
        else $error("hold changed state");

    set_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fall_edge && quiet && prev_q.set_req && !prev_q.reset_req
        |=> outs.q && !outs.q_n)
        else $error("set request not taken");

    reset_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fall_edge && quiet && !prev_q.set_req && prev_q.reset_req
        |=> !outs.q && outs.q_n)
        else $error("reset request not taken");

    no_edge_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !fall_edge && quiet && outs.q != outs.q_n |=> $stable(outs.q))
        else $error("state changed without falling edge");

    preset_pin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!pins.direct_preset_n && pins.direct_clear_n) [*3] |=> outs.q && !outs.q_n)
        else $error("preset pin did not force q high");

    clear_pin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (pins.direct_preset_n && !pins.direct_clear_n) [*3] |=> !outs.q && outs.q_n)
        else $error("clear pin did not force complement high");

    both_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pre_on && clr_on |=> outs.q && outs.q_n)
        else $error("both direct inputs low did not drive both high");

    complement_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !(pre_on && clr_on) |=> outs.q_n == !outs.q)
        else $error("complement output not inverse of q");

    toggle_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        fall_edge && quiet && prev_q.set_req && prev_q.reset_req);
    preset_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        pre_on && !clr_on ##1 quiet);
    both_low_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        pre_on && clr_on);

endmodule
`default_nettype wire

/* jk_pair_pkg.sv */
// shared types and constants for the dual jk storage block
`default_nettype none
package jk_pair_pkg;

    // number of synchroniser flip-flops every pin passes; set and reset requests are read one history stage later
    localparam int unsigned SYNC_STAGES = 2;

    // stored state after sys_rst
    localparam logic RST_STATE = 1'b0;

    // pin group of one element, as seen from the board
    typedef struct packed {
        logic falling_edge_clock;
        logic set_req;
        logic reset_req;
        logic direct_preset_n;
        logic direct_clear_n;
    } pins_s;

    // output pair of one element
    typedef struct packed {
        logic q;
        logic q_n;
    } outs_s;

    // value of a quiet pin group: clock high, both direct inputs inactive
    localparam pins_s PINS_IDLE = '{
        falling_edge_clock: 1'b1,
        set_req:            1'b0,
        reset_req:          1'b0,
        direct_preset_n:    1'b1,
        direct_clear_n:     1'b1
    };

endpackage
`default_nettype wire

/* jk_pair.sv */
// top: two independent jk storage elements sampled on one system clock
// Operation
// - two separate elements, no interaction between them
// - update only on clock pin falling edge
// - use request levels sampled before the edge
// - hold, clear, set or toggle per requests
// - direct inputs force outputs, block clocked updates
// - direct inputs act regardless of clock pin
// - both direct inputs low: both outputs high
`default_nettype none
module jk_pair (
    // system
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // element one pins
    input  wire logic falling_edge_clock_1,
    input  wire logic set_req_1,
    input  wire logic reset_req_1,
    input  wire logic direct_preset_n_1,
    input  wire logic direct_clear_n_1,
    // element two pins
    input  wire logic falling_edge_clock_2,
    input  wire logic set_req_2,
    input  wire logic reset_req_2,
    input  wire logic direct_preset_n_2,
    input  wire logic direct_clear_n_2,
    // outputs
    output logic      q_1,
    output logic      q_n_1,
    output logic      q_2,
    output logic      q_n_2
);

    jk_pair_pkg::pins_s pins_1, pins_2;
    jk_pair_pkg::outs_s outs_1, outs_2;

    // group pins per element; requests are assumed stable near edges
    // as the board guarantees, so one sample per edge suffices
    assign pins_1 = '{falling_edge_clock_1, set_req_1, reset_req_1,
                      direct_preset_n_1, direct_clear_n_1};
    assign pins_2 = '{falling_edge_clock_2, set_req_2, reset_req_2,
                      direct_preset_n_2, direct_clear_n_2};

    // each element owns its pins and state; nothing is shared but clk_sys and sys_rst
    jk_element elem_1 (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pins    (pins_1),
        .outs    (outs_1)
    );

    jk_element elem_2 (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pins    (pins_2),
        .outs    (outs_2)
    );

    assign q_1   = outs_1.q;
    assign q_n_1 = outs_1.q_n;
    assign q_2   = outs_2.q;
    assign q_n_2 = outs_2.q_n;

endmodule
`default_nettype wire

/* board_model.sv */
// board logic model that drives the pin groups of both elements
`default_nettype none
module board_model (
    // system
    input  wire logic               clk_sys,
    // pin groups
    output var  jk_pair_pkg::pins_s p1,
    output var  jk_pair_pkg::pins_s p2
);
    timeunit 1ns;
    timeprecision 100ps;
    // both groups quiet until a scenario moves them
    initial begin
        p1 = jk_pair_pkg::PINS_IDLE;
        p2 = jk_pair_pkg::PINS_IDLE;
    end
    // change one group just after an edge, then let it settle for n cycles
    task automatic put(input int idx, input jk_pair_pkg::pins_s v, input int n);
        @(posedge clk_sys);
        #1;
        if (idx == 1) begin
            p1 = v;
        end else begin
            p2 = v;
        end
        repeat (n) @(posedge clk_sys);
    endtask
    // requests move only while the clock pin is high, held across the fall
    task automatic clock_fall(input int idx, input logic j, input logic k);
        jk_pair_pkg::pins_s v;
        v = (idx == 1) ? p1 : p2;
        v.set_req = j;
        v.reset_req = k;
        put(idx, v, 4);
        v.falling_edge_clock = 1'b0;
        put(idx, v, 8);
        v.falling_edge_clock = 1'b1;
        put(idx, v, 8);
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the dual jk storage block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clk_sys = 1'b0;
    logic               sys_rst = 1'b1;
    jk_pair_pkg::pins_s p1;
    jk_pair_pkg::pins_s p2;
    jk_pair_pkg::pins_s v;
    logic               q_1, q_n_1, q_2, q_n_2;
    logic               e1 = 1'b0;
    logic               e2 = 1'b0;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    board_model u_board_model (.clk_sys(clk_sys), .p1(p1), .p2(p2));
    jk_pair u_jk_pair (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .falling_edge_clock_1(p1.falling_edge_clock), .set_req_1(p1.set_req),
        .reset_req_1(p1.reset_req), .direct_preset_n_1(p1.direct_preset_n),
        .direct_clear_n_1(p1.direct_clear_n),
        .falling_edge_clock_2(p2.falling_edge_clock), .set_req_2(p2.set_req),
        .reset_req_2(p2.reset_req), .direct_preset_n_2(p2.direct_preset_n),
        .direct_clear_n_2(p2.direct_clear_n),
        .q_1(q_1), .q_n_1(q_n_1), .q_2(q_2), .q_n_2(q_n_2)
    );
    // compare all four outputs, so the idle element is watched too
    task automatic chk(input logic [3:0] exp);
        cmp_count++;
        if ({q_1, q_n_1, q_2, q_n_2} !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time,
                     {q_1, q_n_1, q_2, q_n_2}, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // set, hold, toggle twice, clear, hold on each element in turn
    task automatic t_modes();
        logic [5:0] jt;
        logic [5:0] kt;
        jt = 6'h0D;
        kt = 6'h1C;
        for (int idx = 1; idx <= 2; idx++) begin
            for (int i = 0; i < 6; i++) begin
                u_board_model.clock_fall(idx, jt[i], kt[i]);
                if (idx == 1) begin
                    e1 = (jt[i] & kt[i]) ? ~e1 : jt[i] ? 1'b1 : kt[i] ? 1'b0 : e1;
                end else begin
                    e2 = (jt[i] & kt[i]) ? ~e2 : jt[i] ? 1'b1 : kt[i] ? 1'b0 : e2;
                end
                chk({e1, ~e1, e2, ~e2});
            end
        end
        $display("test modes done");
    endtask
    // direct inputs with the clock pin low, overlap, and a blocked edge
    task automatic t_direct();
        v = p1;
        v.falling_edge_clock = 1'b0;
        v.direct_preset_n = 1'b0;
        u_board_model.put(1, v, 8);
        chk({2'b10, e2, ~e2});
        v.direct_clear_n = 1'b0;
        u_board_model.put(1, v, 8);
        chk({2'b11, e2, ~e2});
        v.direct_preset_n = 1'b1;
        v.falling_edge_clock = 1'b1;
        u_board_model.put(1, v, 8);
        chk({2'b01, e2, ~e2});
        u_board_model.clock_fall(1, 1'b1, 1'b0);
        chk({2'b01, e2, ~e2});
        v = p1;
        v.direct_clear_n = 1'b1;
        u_board_model.put(1, v, 8);
        chk({2'b01, e2, ~e2});
        // preset on the second element must leave the first untouched
        v = p2;
        v.direct_preset_n = 1'b0;
        u_board_model.put(2, v, 8);
        e2 = 1'b1;
        chk({2'b01, e2, ~e2});
        v.direct_preset_n = 1'b1;
        u_board_model.put(2, v, 8);
        chk({2'b01, e2, ~e2});
        $display("test direct done");
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(4'h5);
        t_modes();
        t_direct();
        close_out();
    end
endmodule
`default_nettype wire
